/* design/ecl_regs.vh */
// Constants for the EEPROM / OTP configuration loader
`ifndef ECL_REGS_VH
`define ECL_REGS_VH
`define ECL_SK_HALF_CYC  5'h14
`define ECL_WR_TMO_CYC   19'h61A80
`define ECL_IMG_LEN      5'h10
`define ECL_MAC_LEN      5'h06
`define ECL_SIG_EE_FULL  8'hA5
`define ECL_SIG_EE_MAC   8'hAA
`define ECL_SIG_OTP_LO   8'hF3
`define ECL_SIG_OTP_HI   8'hF7
`define ECL_OTP_BASE_LO  10'h001
`define ECL_OTP_BASE_HI  10'h201
`define ECL_OTP_BYTES    1024
// Serial opcodes; all but EWEN are also used as host command codes
`define ECL_OP_EWEN      2'h0
`define ECL_OP_WRITE     2'h1
`define ECL_OP_READ      2'h2
`define ECL_OP_ERASE     2'h3
`define ECL_EWEN_ADDR    9'h180
`define ECL_LEN_LONG     5'h14
`define ECL_LEN_SHORT    5'h0C
// Reset kinds
`define ECL_RK_POR       3'h0
`define ECL_RK_PIN       3'h1
`define ECL_RK_FUND      3'h2
`define ECL_RK_HOT       3'h3
`define ECL_RK_FLR       3'h4
`define ECL_RK_PMS       3'h5
`define ECL_RK_SOFT      3'h6
// Configuration source codes
`define ECL_SRC_DEF      2'h0
`define ECL_SRC_EE       2'h1
`define ECL_SRC_OTP      2'h2
`endif

/* design/ecl_loader.v */
// Configuration loader: three-wire EEPROM master, on-chip OTP array, image replay cache
`timescale 1ns/100ps
`include "ecl_regs.vh"
module ecl_loader #(
    parameter [18:0] WR_TMO_CYC = `ECL_WR_TMO_CYC
) (
    input  wire        sys_clk_in,
    input  wire        sys_rst_in,
    input  wire        load_req_in,
    input  wire [2:0]  load_kind_in,
    input  wire        host_req_in,
    input  wire [1:0]  host_op_in,
    input  wire [8:0]  host_addr_in,
    input  wire [7:0]  host_wdata_in,
    output wire        host_busy_out,
    output reg         host_done_out,
    output reg         host_err_out,
    output reg  [7:0]  host_rdata_out,
    output wire        crs_out,
    output wire        loading_out,
    output reg  [1:0]  cfg_src_out,
    output reg         mac_only_out,
    output reg         cfg_wr_valid_out,
    output reg  [3:0]  cfg_wr_idx_out,
    output reg  [7:0]  cfg_wr_data_out,
    output wire        cfg_wr_pcie_out,
    output wire        cfg_wr_csr_out,
    output reg  [31:0] mac_rx_address_low_out,
    output reg  [15:0] mac_rx_address_high_out,
    output wire        ee_cs_out,
    output wire        ee_sk_out,
    output wire        ee_di_out,
    input  wire        ee_do_in,
    input  wire        otp_prog_req_in,
    input  wire [12:0] otp_prog_bit_in,
    input  wire        otp_rd_req_in,
    input  wire [9:0]  otp_rd_addr_in,
    output reg  [7:0]  otp_rd_data_out,
    input  wire        otp_standby_en_in,
    output wire        otp_ready_out,
    output reg         otp_ready_irq_out,
    output reg         otp_standby_out
);

localparam [7:0] ST_IDLE    = 8'h01;
localparam [7:0] ST_START   = 8'h02;
localparam [7:0] ST_EE_GO   = 8'h04;
localparam [7:0] ST_EE_RUN  = 8'h08;
localparam [7:0] ST_EE_GAP  = 8'h10;
localparam [7:0] ST_EE_POLL = 8'h20;
localparam [7:0] ST_OTP     = 8'h40;
localparam [7:0] ST_REPLAY  = 8'h80;
localparam [4:0] SK_HALF    = `ECL_SK_HALF_CYC;

reg  [7:0]  state_r;
reg  [2:0]  kind_r;
reg         tgt_pcie_r;
reg         tgt_csr_r;
reg         load_act_r;
reg  [4:0]  idx_r;
reg  [4:0]  end_r;
reg  [4:0]  cache_len_r;
reg         cache_ok_r;
reg         src_otp_r;
reg  [9:0]  base_r;
reg         is_host_r;
reg         ewen_pend_r;
reg  [1:0]  hop_r;
reg  [8:0]  haddr_r;
reg  [7:0]  hdata_r;
reg  [18:0] wt_r;
reg         poll_cs_r;
reg  [7:0]  cache_r [0:15];
reg  [7:0]  otp_mem [0:`ECL_OTP_BYTES-1];
reg         eng_busy_r;
reg         eng_done_r;
reg         eng_pre_r;
reg         cs_r;
reg         sk_r;
reg         di_r;
reg  [4:0]  div_r;
reg  [4:0]  cnt_r;
reg  [19:0] sh_r;
reg  [7:0]  rx_r;
reg         do_m1_r;
reg         do_m2_r;
reg         do_m3_r;
reg         do_s_r;
reg         otp_rdy_q_r;
integer     i;

// Start bit, opcode, nine address bits, data byte
function [19:0] ee_word;
    input [1:0] op;
    input [8:0] addr;
    input [7:0] data;
    begin
        ee_word = {1'b1, op, addr, data};
    end
endfunction

// Target of a reset kind as {pcie, csr}
function [1:0] kind_tgt;
    input [2:0] k;
    begin
        case (k)
            `ECL_RK_HOT: kind_tgt = 2'b10;
            `ECL_RK_FLR, `ECL_RK_PMS: kind_tgt = 2'b01;
            default: kind_tgt = 2'b11;
        endcase
    end
endfunction

wire        replay_w = (kind_r == `ECL_RK_HOT) || (kind_r == `ECL_RK_FLR) ||
                       (kind_r == `ECL_RK_PMS);
wire [4:0]  idx_m1_w = idx_r - 5'h01;
wire [9:0]  otp_addr_w = (idx_r == 5'h00) ? 10'h000 : base_r + {5'h00, idx_m1_w};
wire [19:0] word_w = !is_host_r ? ee_word(`ECL_OP_READ, {4'h0, idx_r}, 8'h00) :
                     ewen_pend_r ? ee_word(`ECL_OP_EWEN, `ECL_EWEN_ADDR, 8'h00) :
                     ee_word(hop_r, haddr_r, hdata_r);
wire [4:0]  len_w = (is_host_r && (ewen_pend_r || hop_r == `ECL_OP_ERASE)) ?
                    `ECL_LEN_SHORT : `ECL_LEN_LONG;

assign crs_out         = load_act_r & tgt_pcie_r;
assign loading_out     = load_act_r;
assign cfg_wr_pcie_out = tgt_pcie_r;
assign cfg_wr_csr_out  = tgt_csr_r;
assign host_busy_out   = (state_r != ST_IDLE);
assign ee_cs_out       = cs_r | poll_cs_r;
assign ee_sk_out       = sk_r;
assign ee_di_out       = di_r;
assign otp_ready_out   = !load_act_r && !otp_standby_out;

// Fuses start unprogrammed
initial begin
    for (i = 0; i < `ECL_OTP_BYTES; i = i + 1) begin
        otp_mem[i] = 8'h00;
    end
end

// Data-in from the serial part, counted once two later stages agree
always @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
        do_m1_r <= 1'b0;
        do_m2_r <= 1'b0;
        do_m3_r <= 1'b0;
        do_s_r  <= 1'b0;
    end else begin
        do_m1_r <= ee_do_in;
        do_m2_r <= do_m1_r;
        do_m3_r <= do_m2_r;
        if (do_m2_r == do_m3_r) begin
            do_s_r <= do_m3_r;
        end
    end
end

// Serial frame engine: CS low one half period, then one clock per bit
always @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
        eng_busy_r <= 1'b0;
        eng_done_r <= 1'b0;
        eng_pre_r  <= 1'b0;
        cs_r       <= 1'b0;
        sk_r       <= 1'b0;
        di_r       <= 1'b0;
        div_r      <= 5'h00;
        cnt_r      <= 5'h00;
        sh_r       <= 20'h00000;
        rx_r       <= 8'h00;
    end else begin
        eng_done_r <= 1'b0;
        if (state_r == ST_EE_GO) begin
            eng_busy_r <= 1'b1;
            eng_pre_r  <= 1'b1;
            sh_r       <= word_w;
            di_r       <= word_w[19];
            cnt_r      <= len_w;
            div_r      <= 5'h00;
        end else if (eng_busy_r) begin
            if (div_r == SK_HALF - 5'h01) begin
                div_r <= 5'h00;
                if (eng_pre_r) begin
                    eng_pre_r <= 1'b0;
                    cs_r      <= 1'b1;
                end else if (!sk_r) begin
                    sk_r <= 1'b1;
                end else begin
                    sk_r  <= 1'b0;
                    rx_r  <= {rx_r[6:0], do_s_r};
                    sh_r  <= {sh_r[18:0], 1'b0};
                    di_r  <= sh_r[18];
                    cnt_r <= cnt_r - 5'h01;
                    if (cnt_r == 5'h01) begin
                        eng_busy_r <= 1'b0;
                        eng_done_r <= 1'b1;
                        cs_r       <= 1'b0;
                        di_r       <= 1'b0;
                    end
                end
            end else begin
                div_r <= div_r + 5'h01;
            end
        end
    end
end

task done_load;
    input [4:0] len;
    begin
        load_act_r  <= 1'b0;
        cache_ok_r  <= 1'b1;
        cache_len_r <= len;
        state_r     <= ST_IDLE;
    end
endtask

// One image byte from EEPROM, OTP or cache
task take_byte;
    input [7:0] b;
    input [7:0] st_cont;
    begin
        if (idx_r == 5'h00 && !src_otp_r && b != `ECL_SIG_EE_FULL &&
            b != `ECL_SIG_EE_MAC) begin
            src_otp_r <= 1'b1;
            state_r   <= ST_OTP;
        end else if (idx_r == 5'h00 && src_otp_r && b != `ECL_SIG_OTP_LO &&
                     b != `ECL_SIG_OTP_HI) begin
            done_load(5'h00);
        end else begin
            if (idx_r == 5'h00) begin
                if (src_otp_r) begin
                    base_r <= (b == `ECL_SIG_OTP_LO) ? `ECL_OTP_BASE_LO :
                              `ECL_OTP_BASE_HI;
                    end_r  <= `ECL_IMG_LEN;
                    cfg_src_out <= `ECL_SRC_OTP;
                end else begin
                    end_r <= (b == `ECL_SIG_EE_MAC) ? `ECL_MAC_LEN : `ECL_IMG_LEN;
                    mac_only_out <= (b == `ECL_SIG_EE_MAC);
                    cfg_src_out  <= `ECL_SRC_EE;
                end
            end else begin
                cfg_wr_valid_out <= 1'b1;
                cfg_wr_idx_out   <= idx_m1_w[3:0];
                cfg_wr_data_out  <= b;
                cache_r[idx_m1_w[3:0]] <= b;
                if (tgt_csr_r && idx_m1_w < 5'h04) begin
                    mac_rx_address_low_out[{idx_m1_w[1:0], 3'b000} +: 8] <= b;
                end else if (tgt_csr_r && idx_r <= `ECL_MAC_LEN) begin
                    mac_rx_address_high_out[{idx_m1_w[0], 3'b000} +: 8] <= b;
                end
            end
            if (idx_r != 5'h00 && idx_r == end_r) begin
                done_load(end_r);
            end else begin
                idx_r   <= idx_r + 5'h01;
                state_r <= st_cont;
            end
        end
    end
endtask

// Main sequencer: auto-load, replay and host commands
always @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
        state_r     <= ST_START;
        kind_r      <= `ECL_RK_POR;
        tgt_pcie_r  <= 1'b1;
        tgt_csr_r   <= 1'b1;
        load_act_r  <= 1'b1;
        idx_r       <= 5'h00;
        end_r       <= 5'h00;
        cache_len_r <= 5'h00;
        cache_ok_r  <= 1'b0;
        src_otp_r   <= 1'b0;
        base_r      <= 10'h000;
        is_host_r   <= 1'b0;
        ewen_pend_r <= 1'b0;
        hop_r       <= 2'h0;
        haddr_r     <= 9'h000;
        hdata_r     <= 8'h00;
        wt_r        <= 19'h00000;
        poll_cs_r   <= 1'b0;
        host_done_out    <= 1'b0;
        host_err_out     <= 1'b0;
        host_rdata_out   <= 8'h00;
        cfg_src_out      <= `ECL_SRC_DEF;
        mac_only_out     <= 1'b0;
        cfg_wr_valid_out <= 1'b0;
        cfg_wr_idx_out   <= 4'h0;
        cfg_wr_data_out  <= 8'h00;
        mac_rx_address_low_out  <= 32'h00000000;
        mac_rx_address_high_out <= 16'h0000;
    end else begin
        cfg_wr_valid_out <= 1'b0;
        host_done_out    <= 1'b0;
        case (state_r)
            ST_IDLE: begin
                if (load_req_in) begin
                    kind_r     <= load_kind_in;
                    {tgt_pcie_r, tgt_csr_r} <= kind_tgt(load_kind_in);
                    load_act_r <= 1'b1;
                    state_r    <= ST_START;
                end else if (host_req_in && host_op_in != `ECL_OP_EWEN) begin
                    is_host_r    <= 1'b1;
                    hop_r        <= host_op_in;
                    haddr_r      <= host_addr_in;
                    hdata_r      <= host_wdata_in;
                    ewen_pend_r  <= (host_op_in != `ECL_OP_READ);
                    host_err_out <= 1'b0;
                    state_r      <= ST_EE_GO;
                end
            end
            ST_START: begin
                is_host_r <= 1'b0;
                src_otp_r <= 1'b0;
                if (replay_w && cache_ok_r) begin
                    idx_r   <= 5'h01;
                    end_r   <= cache_len_r;
                    state_r <= ST_REPLAY;
                end else begin
                    idx_r        <= 5'h00;
                    cfg_src_out  <= `ECL_SRC_DEF;
                    mac_only_out <= 1'b0;
                    if (tgt_csr_r) begin
                        mac_rx_address_low_out  <= 32'h00000000;
                        mac_rx_address_high_out <= 16'h0000;
                    end
                    state_r <= ST_EE_GO;
                end
            end
            ST_EE_GO: begin
                state_r <= ST_EE_RUN;
            end
            ST_EE_RUN: begin
                if (eng_done_r) begin
                    if (!is_host_r) begin
                        take_byte(rx_r, ST_EE_GO);
                    end else if (ewen_pend_r) begin
                        ewen_pend_r <= 1'b0;
                        state_r     <= ST_EE_GO;
                    end else if (hop_r == `ECL_OP_READ) begin
                        host_rdata_out <= rx_r;
                        host_done_out  <= 1'b1;
                        state_r        <= ST_IDLE;
                    end else begin
                        wt_r    <= 19'h00000;
                        state_r <= ST_EE_GAP;
                    end
                end
            end
            ST_EE_GAP: begin
                if (wt_r == {14'h0000, SK_HALF}) begin
                    poll_cs_r <= 1'b1;
                    wt_r      <= 19'h00000;
                    state_r   <= ST_EE_POLL;
                end else begin
                    wt_r <= wt_r + 19'h00001;
                end
            end
            ST_EE_POLL: begin
                wt_r <= wt_r + 19'h00001;
                if (wt_r > {14'h0000, SK_HALF} && do_s_r) begin
                    poll_cs_r     <= 1'b0;
                    host_done_out <= 1'b1;
                    state_r       <= ST_IDLE;
                end else if (wt_r == WR_TMO_CYC) begin
                    poll_cs_r     <= 1'b0;
                    host_err_out  <= 1'b1;
                    host_done_out <= 1'b1;
                    state_r       <= ST_IDLE;
                end
            end
            ST_OTP: begin
                take_byte(otp_mem[otp_addr_w], ST_OTP);
            end
            ST_REPLAY: begin
                if (end_r == 5'h00) begin
                    done_load(5'h00);
                end else begin
                    take_byte(cache_r[idx_m1_w[3:0]], ST_REPLAY);
                end
            end
            default: begin
                state_r <= ST_IDLE;
            end
        endcase
    end
end

// OTP programming sets one fuse bit at a time
always @(posedge sys_clk_in) begin
    if (otp_prog_req_in && otp_ready_out) begin
        otp_mem[otp_prog_bit_in[12:3]][otp_prog_bit_in[2:0]] <= 1'b1;
    end
end

// OTP byte reads, standby and ready event
always @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
        otp_rd_data_out   <= 8'h00;
        otp_standby_out   <= 1'b0;
        otp_ready_irq_out <= 1'b0;
        otp_rdy_q_r       <= 1'b0;
    end else begin
        if (otp_rd_req_in && otp_ready_out) begin
            otp_rd_data_out <= otp_mem[otp_rd_addr_in];
        end
        otp_standby_out <= otp_standby_en_in && !load_act_r &&
                           !otp_rd_req_in && !otp_prog_req_in;
        otp_rdy_q_r       <= otp_ready_out;
        otp_ready_irq_out <= otp_ready_out && !otp_rdy_q_r;
    end
end

endmodule // ecl_loader

/* design/ecl_loader_unused_note.v */
// Holds no logic; the whole loader is in ecl_loader.v

/* test/ecl_ee_model.sv */
// Behavioural three-wire serial EEPROM, 512 x 8, with write busy time
`timescale 1ns/100ps
module ecl_ee_model #(
    parameter BUSY_CYC = 100
) (
    input  wire clk_in,
    input  wire cs_in,
    input  wire sk_in,
    input  wire di_in,
    input  wire stuck_in,
    output wire do_out
);
    reg     [7:0]  mem [0:511];
    reg     [19:0] sr_r = 20'h00000;
    reg     [1:0]  op_r = 2'h0;
    reg     [8:0]  addr_r = 9'h000;
    reg            ewen_r = 1'b0;
    reg            rd_bit_r = 1'b0;
    reg            junk_r = 1'b0;
    reg            rdy_r = 1'b1;
    integer        cnt_r = 0;
    integer        frames = 0;
    time           busy_until = 0;
    // Outside a read data phase or status poll the line carries a changing pattern
    assign do_out = (cs_in && cnt_r >= 12 && op_r == 2'h2) ? rd_bit_r :
                    (cs_in && cnt_r == 0) ? (rdy_r && !stuck_in) : junk_r;
    always @(posedge clk_in) begin
        junk_r <= ~junk_r;
        rdy_r <= ($time >= busy_until);
    end
    always @(posedge cs_in) frames = frames + 1;
    always @(posedge sk_in) if (cs_in) begin
        sr_r <= {sr_r[18:0], di_in};
        cnt_r <= cnt_r + 1;
        if (cnt_r == 11) begin
            op_r <= sr_r[9:8];
            addr_r <= {sr_r[7:0], di_in};
            rd_bit_r <= 1'b0;
        end
        if (cnt_r >= 12 && cnt_r < 20 && op_r == 2'h2) rd_bit_r <= mem[addr_r][19 - cnt_r];
    end
    always @(negedge cs_in) begin
        if (op_r == 2'h1 && cnt_r == 20 && ewen_r) begin
            mem[addr_r] <= sr_r[7:0];
            busy_until = $time + BUSY_CYC * 25;
        end
        if (op_r == 2'h3 && cnt_r == 12 && ewen_r) begin
            mem[addr_r] <= 8'hFF;
            busy_until = $time + BUSY_CYC * 25;
        end
        if (op_r == 2'h0 && cnt_r == 12 && addr_r[8:7] == 2'h3) ewen_r <= 1'b1;
        cnt_r <= 0;
        op_r <= 2'h0;
    end
endmodule // ecl_ee_model

/* test/ecl_loader_assertions.sv */
// Port assertions for the configuration loader
`timescale 1ns/100ps
`include "ecl_regs.vh"
module ecl_loader_chk (
    input wire       sys_clk_in,
    input wire       sys_rst_in,
    input wire       load_req_in,
    input wire       host_busy_out,
    input wire       host_done_out,
    input wire       crs_out,
    input wire       loading_out,
    input wire [1:0] cfg_src_out,
    input wire       mac_only_out,
    input wire       ee_cs_out,
    input wire       ee_sk_out,
    input wire       ee_di_out,
    input wire       otp_ready_out,
    input wire       otp_ready_irq_out,
    input wire       otp_standby_out
);
    reg [7:0] sk_hi_r;
    always @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) sk_hi_r <= 8'h00;
        else sk_hi_r <= ee_sk_out ? sk_hi_r + 8'h01 : 8'h00;
    end
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (sys_rst_in);
    chk_crs_in_load:
        assert property (crs_out |-> loading_out) else $error("retry answer outside load");
    chk_load_taken:
        assert property (load_req_in && !host_busy_out |=> loading_out)
        else $error("idle load request not taken");
    chk_mac_only_src:
        assert property (mac_only_out |-> cfg_src_out == `ECL_SRC_EE)
        else $error("mac only without serial source");
    chk_sk_in_frame:
        assert property (ee_sk_out |-> ee_cs_out) else $error("serial clock outside frame");
    chk_sk_half_len:
        assert property ($fell(ee_sk_out) |-> sk_hi_r == `ECL_SK_HALF_CYC)
        else $error("serial clock high time wrong");
    chk_di_stable_hi:
        assert property (ee_sk_out && $past(ee_sk_out) |-> $stable(ee_di_out))
        else $error("data out moved while clock high");
    chk_done_pulse:
        assert property (host_done_out |=> !host_done_out) else $error("done longer than one cycle");
    chk_ready_event:
        assert property ($rose(otp_ready_out) |=> otp_ready_irq_out)
        else $error("missing ready event");
    chk_standby_idle:
        assert property (otp_standby_out |-> !$past(loading_out)) else $error("early standby");
endmodule // ecl_loader_chk
bind ecl_loader ecl_loader_chk u_chk (
    .sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .load_req_in(load_req_in),
    .host_busy_out(host_busy_out), .host_done_out(host_done_out), .crs_out(crs_out),
    .loading_out(loading_out), .cfg_src_out(cfg_src_out), .mac_only_out(mac_only_out),
    .ee_cs_out(ee_cs_out), .ee_sk_out(ee_sk_out), .ee_di_out(ee_di_out),
    .otp_ready_out(otp_ready_out), .otp_ready_irq_out(otp_ready_irq_out),
    .otp_standby_out(otp_standby_out)
);

/* test/ecl_loader_test.sv */
// Self-checking bench for the configuration loader
`timescale 1ns/100ps
`include "ecl_regs.vh"
module ecl_loader_test;
    reg         sys_clk_in = 1'b0;
    reg         sys_rst_in = 1'b1;
    reg         load_req_in = 1'b0;
    reg  [2:0]  load_kind_in = 3'h0;
    reg         host_req_in = 1'b0;
    reg  [1:0]  host_op_in = 2'h0;
    reg  [8:0]  host_addr_in = 9'h000;
    reg  [7:0]  host_wdata_in = 8'h00;
    reg         otp_prog_req_in = 1'b0;
    reg  [12:0] otp_prog_bit_in = 13'h0000;
    reg         otp_rd_req_in = 1'b0;
    reg  [9:0]  otp_rd_addr_in = 10'h000;
    reg         otp_standby_en_in = 1'b0;
    reg         stuck = 1'b0;
    wire        host_busy_out, host_done_out, host_err_out, crs_out, loading_out;
    wire        mac_only_out, cfg_wr_valid_out, cfg_wr_pcie_out, cfg_wr_csr_out;
    wire        ee_cs_out, ee_sk_out, ee_di_out, ee_do_in;
    wire        otp_ready_out, otp_ready_irq_out, otp_standby_out;
    wire [7:0]  host_rdata_out, cfg_wr_data_out, otp_rd_data_out;
    wire [1:0]  cfg_src_out;
    wire [3:0]  cfg_wr_idx_out;
    wire [31:0] mac_rx_address_low_out;
    wire [15:0] mac_rx_address_high_out;
    reg  [7:0]  got [0:15];
    reg  [7:0]  otp_img [0:1023];
    reg  [31:0] r;
    integer     nwr = 0, n0 = 0, f0 = 0, i, k, num_errors = 0, n_compared = 0;
    always #12.5 sys_clk_in = ~sys_clk_in;
    ecl_loader #(.WR_TMO_CYC(19'h007D0)) uut (
        .sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .load_req_in(load_req_in),
        .load_kind_in(load_kind_in), .host_req_in(host_req_in), .host_op_in(host_op_in),
        .host_addr_in(host_addr_in), .host_wdata_in(host_wdata_in),
        .host_busy_out(host_busy_out), .host_done_out(host_done_out),
        .host_err_out(host_err_out), .host_rdata_out(host_rdata_out), .crs_out(crs_out),
        .loading_out(loading_out), .cfg_src_out(cfg_src_out), .mac_only_out(mac_only_out),
        .cfg_wr_valid_out(cfg_wr_valid_out), .cfg_wr_idx_out(cfg_wr_idx_out),
        .cfg_wr_data_out(cfg_wr_data_out), .cfg_wr_pcie_out(cfg_wr_pcie_out),
        .cfg_wr_csr_out(cfg_wr_csr_out), .mac_rx_address_low_out(mac_rx_address_low_out),
        .mac_rx_address_high_out(mac_rx_address_high_out), .ee_cs_out(ee_cs_out),
        .ee_sk_out(ee_sk_out), .ee_di_out(ee_di_out), .ee_do_in(ee_do_in),
        .otp_prog_req_in(otp_prog_req_in), .otp_prog_bit_in(otp_prog_bit_in),
        .otp_rd_req_in(otp_rd_req_in), .otp_rd_addr_in(otp_rd_addr_in),
        .otp_rd_data_out(otp_rd_data_out), .otp_standby_en_in(otp_standby_en_in),
        .otp_ready_out(otp_ready_out), .otp_ready_irq_out(otp_ready_irq_out),
        .otp_standby_out(otp_standby_out));
    ecl_ee_model ee (.clk_in(sys_clk_in), .cs_in(ee_cs_out), .sk_in(ee_sk_out),
        .di_in(ee_di_out), .stuck_in(stuck), .do_out(ee_do_in));
    always @(posedge sys_clk_in) if (cfg_wr_valid_out === 1'b1) begin
        got[cfg_wr_idx_out] <= cfg_wr_data_out;
        nwr <= nwr + 1;
    end
    task summarize;
        begin
            $display("compared %0d, mismatches %0d", n_compared, num_errors);
            if (num_errors == 0 && n_compared > 0) $display("*** PASS ***");
            else $display("*** FAIL ***");
            $finish;
        end
    endtask
    task chk(input [31:0] seen, input [31:0] exp);
        begin
            n_compared = n_compared + 1;
            if (seen !== exp) begin
                num_errors = num_errors + 1;
                $display("MISMATCH at %0t: got %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task wait_on(input integer lim);
        integer n;
        begin
            n = 0;
            @(posedge sys_clk_in);
            while (host_busy_out !== 1'b0 && host_done_out !== 1'b1 && n < lim) begin
                @(posedge sys_clk_in);
                n = n + 1;
            end
            @(posedge sys_clk_in);
            if (n == lim) begin
                num_errors = num_errors + 1;
                $display("MISMATCH at %0t: wait ran out", $time);
                summarize();
            end
        end
    endtask
    task load(input [2:0] kind);
        begin
            n0 = nwr;
            f0 = ee.frames;
            @(posedge sys_clk_in);
            load_req_in <= 1'b1;
            load_kind_in <= kind;
            @(posedge sys_clk_in);
            load_req_in <= 1'b0;
            wait_on(40000);
        end
    endtask
    task host(input [1:0] op, input [8:0] a, input [7:0] d);
        begin
            @(posedge sys_clk_in);
            host_req_in <= 1'b1;
            host_op_in <= op;
            host_addr_in <= a;
            host_wdata_in <= d;
            @(posedge sys_clk_in);
            host_req_in <= 1'b0;
            wait_on(20000);
        end
    endtask
    task prog(input [9:0] a, input [7:0] v);
        integer b;
        begin
            for (b = 0; b < 8; b = b + 1) if (v[b]) begin
                @(posedge sys_clk_in);
                otp_prog_req_in <= 1'b1;
                otp_prog_bit_in <= {a, b[2:0]};
                @(posedge sys_clk_in);
                otp_prog_req_in <= 1'b0;
            end
            otp_img[a] = otp_img[a] | v;
        end
    endtask
    function [7:0] eb(input otp, input integer a);
        eb = otp ? otp_img[a] : ee.mem[a];
    endfunction
    task chk_img(input [1:0] src, input integer n, input integer b, input otp, input [2:0] k);
        integer j;
        begin
            chk(cfg_src_out, src);
            chk(nwr - n0, n);
            chk(cfg_wr_pcie_out, k != `ECL_RK_FLR && k != `ECL_RK_PMS);
            chk(cfg_wr_csr_out, k != `ECL_RK_HOT);
            for (j = 0; j < n; j = j + 1) chk(got[j], eb(otp, b + j));
            if (n > 5) begin
                chk(mac_rx_address_low_out, {eb(otp, b + 3), eb(otp, b + 2), eb(otp, b + 1),
                    eb(otp, b)});
                chk(mac_rx_address_high_out, {eb(otp, b + 5), eb(otp, b + 4)});
            end
        end
    endtask
    initial begin
        r = $urandom(32'h930E);
        for (i = 0; i < 1024; i = i + 1) otp_img[i] = 8'h00;
        for (i = 0; i < 512; i = i + 1) begin
            r = $urandom;
            ee.mem[i] = r[7:0];
        end
        ee.mem[0] = `ECL_SIG_EE_FULL;
        repeat (3) @(posedge sys_clk_in);
        chk(crs_out, 1);
        repeat (3) @(posedge sys_clk_in);
        sys_rst_in <= 1'b0;
        @(posedge sys_clk_in);
        wait_on(40000);
        chk_img(`ECL_SRC_EE, 16, 1, 0, `ECL_RK_POR);
        chk(mac_only_out, 0);
        ee.mem[0] = `ECL_SIG_EE_MAC;
        load(`ECL_RK_PIN);
        chk_img(`ECL_SRC_EE, 6, 1, 0, `ECL_RK_PIN);
        chk(mac_only_out, 1);
        $display("test serial images done");
        ee.mem[0] = 8'h00;
        for (i = 1; i < 17; i = i + 1) begin
            r = $urandom;
            prog(i[9:0], r[7:0]);
        end
        load(`ECL_RK_FUND);
        chk_img(`ECL_SRC_DEF, 0, 0, 0, `ECL_RK_FUND);
        chk(mac_rx_address_low_out, 0);
        prog(10'h000, `ECL_SIG_OTP_LO);
        @(posedge sys_clk_in);
        otp_rd_req_in <= 1'b1;
        @(posedge sys_clk_in);
        otp_rd_req_in <= 1'b0;
        @(posedge sys_clk_in);
        chk(otp_rd_data_out, `ECL_SIG_OTP_LO);
        load(`ECL_RK_SOFT);
        chk_img(`ECL_SRC_OTP, 16, 1, 1, `ECL_RK_SOFT);
        chk(mac_only_out, 0);
        ee.mem[0] = `ECL_SIG_EE_MAC;
        load(`ECL_RK_POR);
        chk_img(`ECL_SRC_EE, 6, 1, 0, `ECL_RK_POR);
        ee.mem[0] = 8'h00;
        prog(10'h000, `ECL_SIG_OTP_HI);
        for (i = 513; i < 529; i = i + 1) begin
            r = $urandom;
            prog(i[9:0], r[7:0]);
        end
        for (k = 0; k < 7; k = k + 1) begin
            load(k[2:0]);
            chk_img(`ECL_SRC_OTP, 16, 513, 1, k[2:0]);
            chk(ee.frames == f0, k >= 3 && k <= 5);
        end
        $display("test otp images done");
        for (i = 0; i < 5; i = i + 1) begin
            r = $urandom;
            k = (i == 0) ? 9'h0FF : (i == 1) ? 9'h100 : (i == 2) ? 9'h1FF : r[16:8];
            host(`ECL_OP_READ, k[8:0], 8'h00);
            chk(host_rdata_out, ee.mem[k]);
        end
        host(`ECL_OP_WRITE, k[8:0], r[7:0]);
        chk(host_err_out, 0);
        host(`ECL_OP_READ, k[8:0], 8'h00);
        chk(host_rdata_out, r[7:0]);
        host(`ECL_OP_ERASE, k[8:0], 8'h00);
        host(`ECL_OP_READ, k[8:0], 8'h00);
        chk(host_rdata_out, 8'hFF);
        stuck <= 1'b1;
        host(`ECL_OP_WRITE, k[8:0], r[7:0]);
        chk(host_err_out, 1);
        stuck <= 1'b0;
        $display("test host access done");
        otp_standby_en_in <= 1'b1;
        repeat (3) @(posedge sys_clk_in);
        chk(otp_standby_out, 1);
        chk(otp_ready_out, 0);
        otp_standby_en_in <= 1'b0;
        repeat (3) @(posedge sys_clk_in);
        chk(otp_ready_out, 1);
        chk(otp_ready_irq_out, 1);
        $display("test otp standby done");
        summarize();
    end
endmodule // ecl_loader_test
